// [hw/pin_ctl_pkg.sv]
// Constants, register map and carrier types for the pin control block.
// Assumes a 200 MHz CPU clock and a 32-bit classic Wishbone register bus.
package pin_ctl_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned RST_PULSE_NS   = 100;
  localparam int unsigned RST_PULSE_CYC  = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_SYS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PENDING  = 8'h04;
  localparam logic [7:0] OFS_GPIO_DIR = 8'h08;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h0C;
  localparam logic [7:0] OFS_GPIO_IN  = 8'h10;

  // ==========================================================================
  // Field positions of system_control_status
  localparam int unsigned BIT_CLOCK_OUT_PIN_EN  = 0;
  localparam int unsigned BIT_STE_SEL    = 1;
  localparam int unsigned BIT_IRQ1_EN    = 2;
  localparam int unsigned BIT_IRQ2_EN    = 3;
  localparam int unsigned BIT_IRQ1_RISE  = 4;
  localparam int unsigned BIT_IRQ2_RISE  = 5;
  localparam int unsigned BIT_CLOCK_OUT_PIN_SEL = 14;

  // Pending flag positions.
  localparam int unsigned PND_FAULT_A = 0;
  localparam int unsigned PND_FAULT_B = 1;
  localparam int unsigned PND_IRQ1    = 2;
  localparam int unsigned PND_IRQ2    = 3;

  // GPIO pin indices.
  localparam int unsigned PIN_C5 = 0;
  localparam int unsigned PIN_A2 = 1;
  localparam int unsigned PIN_D0 = 2;
  localparam int unsigned PIN_E0 = 3;

  // Reset values.
  localparam logic [15:0] SYS_CTRL_RST = 16'h0000;
  localparam logic [3:0]  PENDING_RST  = 4'h0;
  localparam logic [3:0]  GPIO_DIR_RST = 4'h0;
  localparam logic [3:0]  GPIO_OUT_RST = 4'h0;

  // Drive of one pin: level and output enable.
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drv_s;

endpackage

// [hw/pin_ctl.sv]
// Pin control logic: system reset pin, drive fault inputs, external interrupts,
// clock output pin and their GPIO fallbacks.
// Assumes pin buffers outside resolve level from o/oe; watchdog overflow comes
// as a one-cycle pulse on clk_i.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps

module pin_ctl
  import pin_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Reset pin and watchdog
  input  wire logic        reset_n_pin_i,
  output pin_drv_s         reset_n_pin_o,
  input  wire logic        wd_overflow_i,
  input  wire logic        watchdog_clock_i,
  // Drive fault inputs
  input  wire logic        drive_fault_in_a_i,
  input  wire logic        drive_fault_in_b_i,
  // Multiplexed GPIO pins: c5, a2, d0, e0
  input  wire logic [3:0]  gpio_i,
  output pin_drv_s  [3:0]  gpio_o,
  // Towards the core and peripherals
  output logic             cpu_hold_o,
  output logic             fetch_start_o,
  output logic             pwm_hiz_a_o,
  output logic             pwm_hiz_b_o,
  output logic      [3:0]  irq_o,
  output logic             conv_start_o,
  output logic             serial_slave_tx_enable_o
);

  // ==========================================================================
  // Input synchronisers
  // Bit order: gpio[3:0], fault a, fault b, reset pin, watchdog clock.
  logic [7:0] raw_in;
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] prev_r;

  assign raw_in = {watchdog_clock_i, reset_n_pin_i, drive_fault_in_b_i,
                   drive_fault_in_a_i, gpio_i};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_r <= 8'hFF;
      sync2_r <= 8'hFF;
      prev_r  <= 8'hFF;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ==========================================================================
  // System reset: pin or watchdog pulse
  localparam logic [4:0] PULSE_LEN = 5'(RST_PULSE_CYC);
  logic [4:0] pulse_cnt_r;
  logic       sys_rst;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pulse_cnt_r <= 5'h00;
    end else if (wd_overflow_i && pulse_cnt_r == 5'h00) begin
      pulse_cnt_r <= PULSE_LEN;
    end else if (pulse_cnt_r != 5'h00) begin
      pulse_cnt_r <= pulse_cnt_r - 5'h01;
    end
  end

  // The driven pulse reads back through the synchroniser, so the internal
  // reset outlasts the pulse by the two synchroniser stages.
  assign sys_rst = !sync2_r[6] || (pulse_cnt_r != 5'h00);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reset_n_pin_o <= '{o: 1'b0, oe: 1'b0};
      cpu_hold_o    <= 1'b1;
      fetch_start_o <= 1'b0;
    end else begin
      reset_n_pin_o <= '{o: 1'b0, oe: (pulse_cnt_r != 5'h00) || wd_overflow_i};
      cpu_hold_o    <= sys_rst;
      fetch_start_o <= !sys_rst && cpu_hold_o;
    end
  end

  // ==========================================================================
  // Registers
  logic [15:0] ctrl_r;
  logic [3:0]  pend_r;
  logic [3:0]  dir_r;
  logic [3:0]  out_r;
  logic        wr_stb;
  logic [3:0]  pend_set;
  logic [3:0]  pend_clr;

  assign wr_stb = cyc_i && stb_i && we_i && !ack_o;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= SYS_CTRL_RST;
      dir_r  <= GPIO_DIR_RST;
      out_r  <= GPIO_OUT_RST;
    end else if (sys_rst) begin
      ctrl_r <= SYS_CTRL_RST;
      dir_r  <= GPIO_DIR_RST;
      out_r  <= GPIO_OUT_RST;
    end else if (wr_stb) begin
      if (adr_i == OFS_SYS_CTRL) begin
        if (sel_i[0]) ctrl_r[7:0]  <= dat_i[7:0];
        if (sel_i[1]) ctrl_r[15:8] <= dat_i[15:8];
      end
      if (adr_i == OFS_GPIO_DIR && sel_i[0]) dir_r <= dat_i[3:0];
      if (adr_i == OFS_GPIO_OUT && sel_i[0]) out_r <= dat_i[3:0];
    end
  end

  // ==========================================================================
  // Edge detection and pending flags
  logic fault_a_fall;
  logic fault_b_fall;
  logic irq1_edge;
  logic irq2_edge;

  assign fault_a_fall = prev_r[4] && !sync2_r[4];
  assign fault_b_fall = prev_r[5] && !sync2_r[5];
  assign irq1_edge = ctrl_r[BIT_IRQ1_EN] &&
                     (ctrl_r[BIT_IRQ1_RISE] ? (sync2_r[PIN_A2] && !prev_r[PIN_A2])
                                            : (!sync2_r[PIN_A2] && prev_r[PIN_A2]));
  assign irq2_edge = ctrl_r[BIT_IRQ2_EN] &&
                     (ctrl_r[BIT_IRQ2_RISE] ? (sync2_r[PIN_D0] && !prev_r[PIN_D0])
                                            : (!sync2_r[PIN_D0] && prev_r[PIN_D0]));

  assign pend_set = {irq2_edge, irq1_edge, fault_b_fall, fault_a_fall};
  assign pend_clr = (wr_stb && adr_i == OFS_PENDING && sel_i[0]) ? dat_i[3:0] : 4'h0;

  // A new edge in the clearing cycle wins so that no event is lost.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_r <= PENDING_RST;
    end else if (sys_rst) begin
      pend_r <= PENDING_RST;
    end else begin
      pend_r <= (pend_r & ~pend_clr) | pend_set;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwm_hiz_a_o  <= 1'b0;
      pwm_hiz_b_o  <= 1'b0;
      irq_o        <= 4'h0;
      conv_start_o <= 1'b0;
    end else begin
      // The PWM outputs stay floated until software or a system reset clears the fault flag.
      pwm_hiz_a_o  <= pend_r[PND_FAULT_A] || fault_a_fall;
      pwm_hiz_b_o  <= pend_r[PND_FAULT_B] || fault_b_fall;
      irq_o        <= (pend_r & ~pend_clr) | pend_set;
      conv_start_o <= irq2_edge;
    end
  end

  // ==========================================================================
  // Pin multiplexing
  // The CPU clock is shown at half rate, since the pin comes from a flop.
  logic cpu_clk_div_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_clk_div_r <= 1'b0;
    end else begin
      cpu_clk_div_r <= !cpu_clk_div_r;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gpio_o                   <= '0;
      serial_slave_tx_enable_o <= 1'b1;
    end else if (sys_rst) begin
      gpio_o                   <= '0;
      serial_slave_tx_enable_o <= 1'b1;
    end else begin
      for (int i = 0; i < 4; i++) begin
        gpio_o[i] <= '{o: out_r[i], oe: dir_r[i]};
      end
      if (ctrl_r[BIT_STE_SEL]) begin
        gpio_o[PIN_C5] <= '{o: 1'b0, oe: 1'b0};
      end
      if (ctrl_r[BIT_IRQ1_EN]) begin
        gpio_o[PIN_A2] <= '{o: 1'b0, oe: 1'b0};
      end
      if (ctrl_r[BIT_IRQ2_EN]) begin
        gpio_o[PIN_D0] <= '{o: 1'b0, oe: 1'b0};
      end
      if (ctrl_r[BIT_CLOCK_OUT_PIN_EN]) begin
        gpio_o[PIN_E0] <= '{o: ctrl_r[BIT_CLOCK_OUT_PIN_SEL] ? sync2_r[7] : cpu_clk_div_r,
                            oe: 1'b1};
      end
      serial_slave_tx_enable_o <= ctrl_r[BIT_STE_SEL] ? sync2_r[PIN_C5] : 1'b1;
    end
  end

  // ==========================================================================
  // Wishbone answer: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      case (adr_i)
        OFS_SYS_CTRL: dat_o <= {16'h0000, ctrl_r};
        OFS_PENDING:  dat_o <= {28'h000_0000, pend_r};
        OFS_GPIO_DIR: dat_o <= {28'h000_0000, dir_r};
        OFS_GPIO_OUT: dat_o <= {28'h000_0000, out_r};
        OFS_GPIO_IN:  dat_o <= {24'h00_0000, sync2_r};
        default:      dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Most checks look one cycle ahead, since every output leaves a flop.
  hold_in_reset_a: assert property (sys_rst |=> cpu_hold_o)
    else $error("core not held during reset");
  fetch_start_a: assert property (
      fetch_start_o |-> !cpu_hold_o && $past(cpu_hold_o) ##1 !fetch_start_o)
    else $error("fetch start not a single pulse at release");
  regs_cleared_a: assert property (
      cpu_hold_o |-> ctrl_r == SYS_CTRL_RST && pend_r == PENDING_RST)
    else $error("registers not at reset value during reset");
  wd_pulse_a: assert property (
      wd_overflow_i && pulse_cnt_r == 5'h00 |=> (reset_n_pin_o.oe && !reset_n_pin_o.o) [*8])
    else $error("watchdog reset pulse not driven on pin");
  fault_a_hiz_a: assert property (fault_a_fall && !sys_rst |=> pwm_hiz_a_o && irq_o[0])
    else $error("fault a did not float pwm");
  fault_b_hiz_a: assert property (fault_b_fall && !sys_rst |=> pwm_hiz_b_o && irq_o[1])
    else $error("fault b did not float pwm");
  float_hold_a: assert property (pend_r[PND_FAULT_A] |=> pwm_hiz_a_o)
    else $error("pwm a released while fault a pending");
  float_hold_b_a: assert property (pend_r[PND_FAULT_B] |=> pwm_hiz_b_o)
    else $error("pwm b released while fault b pending");
  irq_polarity_a: assert property (
      !sys_rst && ctrl_r[BIT_IRQ2_EN] && ctrl_r[BIT_IRQ2_RISE]
      && $rose(sync2_r[PIN_D0]) |=> pend_r[PND_IRQ2])
    else $error("rising edge on interrupt 2 not latched");
  irq_fall_a: assert property (
      !sys_rst && ctrl_r[BIT_IRQ1_EN] && !ctrl_r[BIT_IRQ1_RISE]
      && $fell(sync2_r[PIN_A2]) |=> pend_r[PND_IRQ1])
    else $error("falling edge on interrupt 1 not latched");
  conv_start_a: assert property (
      conv_start_o == $past(irq2_edge) && (!conv_start_o || irq_o[PND_IRQ2]))
    else $error("conversion start not tied to interrupt 2 edge");
  clk_select_a: assert property (
      !sys_rst && ctrl_r[BIT_CLOCK_OUT_PIN_EN] && ctrl_r[BIT_CLOCK_OUT_PIN_SEL]
      |=> gpio_o[PIN_E0].o == $past(sync2_r[7]))
    else $error("clock pin not carrying watchdog clock");
  clk_gpio_a: assert property (
      !sys_rst && !ctrl_r[BIT_CLOCK_OUT_PIN_EN] |=> gpio_o[PIN_E0].oe == $past(dir_r[PIN_E0]))
    else $error("clock pin not acting as gpio");
  gpio_input_a: assert property ($fell(cpu_hold_o) |-> gpio_o == '0)
    else $error("gpio not input after reset");
  ste_pin_a: assert property (!sys_rst && ctrl_r[BIT_STE_SEL] |=> !gpio_o[PIN_C5].oe)
    else $error("transmit enable pin still driven");
  ste_level_a: assert property (
      !sys_rst && ctrl_r[BIT_STE_SEL] |=> serial_slave_tx_enable_o == $past(sync2_r[PIN_C5]))
    else $error("transmit enable not following its pin");
  pend_hold_a: assert property (
      !sys_rst && pend_r[PND_IRQ2] && !pend_clr[PND_IRQ2] |=> pend_r[PND_IRQ2])
    else $error("pending flag lost without clear");
  bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer not a single cycle pulse");

  wd_reset_c: cover property (wd_overflow_i ##[1:40] fetch_start_o);
  fault_clear_c: cover property (pwm_hiz_a_o ##[1:20] !pwm_hiz_a_o);
  irq2_c: cover property (conv_start_o && ctrl_r[BIT_IRQ2_RISE]);
  clr_race_c: cover property (|(pend_clr & pend_set));

endmodule

// [verification/pin_board.sv]
// Board model beside the pin block: pull-ups, reset source, watchdog clock.
// Assumes each device pin drive arrives as a {o,oe} pair on clk_i.
`timescale 1ns/1ps
module pin_board
  import pin_ctl_pkg::*;
(
  // Device side
  input  wire logic       clk_i,
  input  pin_drv_s        rst_drv_i,
  input  pin_drv_s [3:0]  gpio_drv_i,
  // Board sources
  input  wire logic       board_rst_i,
  input  wire logic [3:0] src_i,
  // Resolved pins
  output logic            rst_pin_o,
  output logic [3:0]      gpio_pin_o,
  output logic            watchdog_clock_o
);
  // ==========================================================================
  // Pin resolution
  logic [2:0] div_r = 3'h0;
  // The reset line is wired-low, so either party pulls it down.
  assign rst_pin_o = !(rst_drv_i.oe || board_rst_i);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gpio_pin_o[i] = gpio_drv_i[i].oe ? gpio_drv_i[i].o : src_i[i];
    end
  end
  always @(posedge clk_i) begin
    div_r <= div_r + 3'h1;
  end
  assign watchdog_clock_o = div_r[2];
endmodule

// [verification/pin_ctl_bench.sv]
// Self-checking bench for the pin block, driven over classic Wishbone.
// Assumes pin_board resolves the pins and a 200 MHz clock.
`timescale 1ns/1ps
module pin_ctl_bench;
  import pin_ctl_pkg::*;
  logic           clk_i = 1'b0;
  logic           resetn_i = 1'b0;
  logic           cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic           wd_ovf = 1'b0, board_rst = 1'b0, flt_a = 1'b1, flt_b = 1'b1;
  logic [7:0]     adr = 8'h00;
  logic [31:0]    wdat = 32'h0, rdat, q;
  logic [3:0]     src = 4'hF, irq, gpio_pin;
  logic           ack, hold, fetch, hiz_a, hiz_b, conv, ste, rst_pin, watchdog_clock, last;
  pin_drv_s       rst_drv;
  pin_drv_s [3:0] gpio_drv;
  wire [3:0]      oe_v = {gpio_drv[3].oe, gpio_drv[2].oe, gpio_drv[1].oe, gpio_drv[0].oe};
  int             n_errors = 0, cmp_count = 0, cycles = 0, n_fetch = 0, n_conv = 0;
  int             n_low = 0, f0, tr;
  always #2.5 clk_i = ~clk_i;

  pin_ctl dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .reset_n_pin_i(rst_pin), .reset_n_pin_o(rst_drv), .wd_overflow_i(wd_ovf),
    .watchdog_clock_i(watchdog_clock), .drive_fault_in_a_i(flt_a), .drive_fault_in_b_i(flt_b),
    .gpio_i(gpio_pin), .gpio_o(gpio_drv), .cpu_hold_o(hold), .fetch_start_o(fetch),
    .pwm_hiz_a_o(hiz_a), .pwm_hiz_b_o(hiz_b), .irq_o(irq), .conv_start_o(conv),
    .serial_slave_tx_enable_o(ste));
  pin_board board_u (.clk_i(clk_i), .rst_drv_i(rst_drv), .gpio_drv_i(gpio_drv),
    .board_rst_i(board_rst), .src_i(src), .rst_pin_o(rst_pin),
    .gpio_pin_o(gpio_pin), .watchdog_clock_o(watchdog_clock));

  // ==========================================================================
  // Monitors and timeout
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (fetch === 1'b1) n_fetch <= n_fetch + 1;
    if (conv === 1'b1) n_conv <= n_conv + 1;
    if (rst_drv.oe === 1'b1) n_low <= n_low + 1;
    if (cycles == 6000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Read data is taken at the ack edge, before the slave can change it.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_run();
    for (int k = 0; k < 80 && hold !== 1'b0; k++) tick(1);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    tick(6);
    resetn_i <= 1'b1;
    tick(3);
    chk("hold", hold, 0);
    chk("fetch", n_fetch, 1);
    chk("gpio_oe", oe_v, 0);
    chk("ste", ste, 1);
    wb(0, OFS_SYS_CTRL, 0); chk("sys", q, SYS_CTRL_RST);
    wb(0, OFS_PENDING, 0); chk("pend", q, PENDING_RST);
    wb(0, OFS_GPIO_DIR, 0); chk("dir", q, GPIO_DIR_RST);
    wb(0, 8'h20, 0); chk("unmapped", q, 0);
    $display("reset test done");
    wb(1, OFS_GPIO_DIR, 32'hF); wb(1, OFS_GPIO_OUT, 32'h5); tick(4);
    chk("gpio_oe", oe_v, 4'hF);
    wb(0, OFS_GPIO_IN, 0); chk("gpio_in", q[3:0], 4'h5);
    wb(1, OFS_GPIO_DIR, 0);
    $display("gpio test done");
    for (int i = 0; i < 2; i++) begin
      if (i == 0) flt_a <= 1'b0;
      else flt_b <= 1'b0;
      tick(6);
      chk("hiz", {hiz_b, hiz_a}, 2'b01 << i);
      chk("irq", irq, 4'b0001 << i);
      flt_a <= 1'b1; flt_b <= 1'b1;
      wb(1, OFS_PENDING, 32'h1 << i); tick(2);
      chk("irq_clr", {hiz_b, hiz_a, irq}, 0);
    end
    $display("fault test done");
    wb(1, OFS_SYS_CTRL, 32'h2C);
    src[1] <= 1'b0; src[2] <= 1'b0; tick(6);
    chk("irq_edge", irq, 4'b0100);
    src[2] <= 1'b1; tick(6);
    chk("irq_rise", irq, 4'b1100);
    chk("conv", n_conv, 1);
    src <= 4'hF; wb(1, OFS_PENDING, 32'hC); tick(2);
    chk("irq_clr", irq, 0);
    wb(1, OFS_SYS_CTRL, 32'h1C);
    src[1] <= 1'b0; src[2] <= 1'b0; tick(6);
    chk("irq_fall2", irq, 4'b1000);
    chk("conv2", n_conv, 2);
    src <= 4'hF; tick(6);
    chk("irq_rise1", irq, 4'b1100);
    wb(1, OFS_PENDING, 32'hC); tick(2);
    chk("irq_clr2", irq, 0);
    $display("interrupt test done");
    for (int s = 0; s < 2; s++) begin
      wb(1, OFS_SYS_CTRL, 32'h1 | (s << BIT_CLOCK_OUT_PIN_SEL)); tick(4);
      tr = 0; last = gpio_drv[3].o;
      repeat (32) begin
        tick(1);
        if (gpio_drv[3].o !== last) tr++;
        last = gpio_drv[3].o;
      end
      chk("clk_oe", oe_v[3], 1);
      chk("clk_rate", s ? (tr >= 6 && tr <= 10) : tr >= 24, 1);
    end
    wb(1, OFS_SYS_CTRL, 32'h2); tick(3);
    chk("clk_off", oe_v[3], 0);
    src[0] <= 1'b0; tick(5);
    chk("ste_lo", ste, 0);
    src[0] <= 1'b1; tick(5);
    chk("ste_hi", ste, 1);
    $display("pin function test done");
    f0 = n_fetch;
    wd_ovf <= 1'b1; tick(1); wd_ovf <= 1'b0; tick(2);
    chk("rst_pin", rst_pin, 0);
    chk("hold_wd", hold, 1);
    wait_run(); tick(1);
    chk("pulse_len", n_low, RST_PULSE_CYC + 1);
    chk("refetch", n_fetch, f0 + 1);
    wb(1, OFS_SYS_CTRL, 32'h4002); wb(0, OFS_SYS_CTRL, 0);
    chk("sys_set", q, 32'h4002);
    board_rst <= 1'b1; tick(5);
    chk("hold_pin", hold, 1);
    board_rst <= 1'b0; wait_run(); tick(2);
    chk("refetch_pin", n_fetch, f0 + 2);
    wb(0, OFS_SYS_CTRL, 0); chk("sys_clr", q, SYS_CTRL_RST);
    $display("reset pin test done");
    report_and_stop();
  end
endmodule
